// [design/uwm_params.svh]
// Register indices, field positions, codes and counts for the serial port
`ifndef UWM_PARAMS_SVH
`define UWM_PARAMS_SVH
`define UWM_REG_DATA   3'h0
`define UWM_REG_MASK   3'h1
`define UWM_REG_SRC    3'h2
`define UWM_REG_FMT    3'h3
`define UWM_REG_MCTL   3'h4
`define UWM_REG_LSTAT  3'h5
`define UWM_REG_MSTAT  3'h6
`define UWM_REG_SCR    3'h7
`define UWM_FMT_STOP   2
`define UWM_FMT_PEN    3
`define UWM_FMT_EVEN   4
`define UWM_FMT_STICK  5
`define UWM_FMT_BREAK  6
`define UWM_FMT_DIV    7
`define UWM_MCR_LOOP   4
`define UWM_MASK_RX    0
`define UWM_MASK_THRE  1
`define UWM_MASK_LINE  2
`define UWM_MASK_MODEM 3
`define UWM_SRC_LINE   3'h6
`define UWM_SRC_RX     3'h4
`define UWM_SRC_THRE   3'h2
`define UWM_SRC_MODEM  3'h0
`define UWM_SRC_NONE   3'h1
`define UWM_TICK_LAST  5'h0f
`define UWM_MID_LAST   5'h07
`define UWM_STOP15     5'h17
`define UWM_STOP2      5'h1f
`define UWM_LEN_BASE   3'h4
`define UWM_LEN_FIVE   2'h0
`define UWM_DIV_RESET  16'h0000
`endif

// [design/uwm_pkg.sv]
// Types shared by the serial port design
package uwm_pkg;
  typedef enum logic [2:0] {
    UWM_IDLE,
    UWM_START,
    UWM_DATA,
    UWM_PARITY,
    UWM_STOP
  } uwm_phase_e;

  typedef struct packed {
    uwm_phase_e  phase;
    logic [4:0]  ticks;
    logic [2:0]  bits;
    logic [7:0]  tx_shifter;
    logic [7:0]  hold;
    logic        hold_full;
    logic        line;
  } uwm_tx_s;

  typedef struct packed {
    uwm_phase_e  phase;
    logic [4:0]  ticks;
    logic [2:0]  bits;
    logic [7:0]  shift;
    logic        par_bit;
    logic        prev_line;
  } uwm_rx_s;

  typedef struct packed {
    logic [7:0]  line_format;
    logic [3:0]  interrupt_mask;
    logic [4:0]  modem_output_control;
    logic [15:0] divisor;
    logic [7:0]  scratch_byte;
    logic [7:0]  receive_buffer;
    logic        rx_data_waiting;
    logic [3:0]  errs;
    logic        thre_int;
    logic [3:0]  modem_prev;
    logic [3:0]  delta;
    logic [7:0]  rd_data;
    logic        rd_oe;
    logic        irq;
  } uwm_ctl_s;
endpackage : uwm_pkg

// [design/uwm_top.sv]
// Serial receiver/transmitter with modem pins and host register port
//
// Behaviour
// - Interrupt high while any enabled source pends
// - Control bits 0,1 drive ready/request pins inverted
// - Control bits 2,3 drive user outputs inverted
// - Reset clears registers, idles transmitter and receiver
// - Modem pins never affect transmit or receive
// - Format bit 7 maps indices 0,1 to divisor
// - Data write loads holding register when free
// - Holding-empty flag sets on transfer or on enable while empty
// - Receiver waits half bit after falling edge
// - Start bit rejected unless still low
// - Sixteen-bit divisor divides the input clock
// - Divided clock output runs at sixteen times rate
// - Mask gates four sources; upper bits zero
// - Source register reports highest pending enabled source
// - Source bit 0 low while any enabled source pends
// - Format bits 1:0 give 5 to 8 bits
// - Format bit 2 selects longer stop time
// - Format bits 3,4 enable and select parity
// - Format bit 5 forces a constant parity
// - Format bit 6 holds output low (break) except in loop-back
// - Loop-back routes transmitter and modem internally
`timescale 1ns/1ps
`include "uwm_params.svh"

module uwm_top #(
  parameter int DIV_WIDTH = 16
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic [2:0] reg_select_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  input  wire logic       serial_in_i,
  output logic            serial_out_o,
  input  wire logic       clear_to_send_n_i,
  input  wire logic       data_set_ready_n_i,
  input  wire logic       ring_indicate_n_i,
  input  wire logic       carrier_found_n_i,
  output logic            terminal_ready_n_o,
  output logic            send_request_n_o,
  output logic            user_out_a_n_o,
  output logic            user_out_b_n_o,
  output logic            rate_clock_out_n_o,
  output logic            interrupt_o
);

  uwm_pkg::uwm_tx_s  tx;
  uwm_pkg::uwm_tx_s  next_tx;
  uwm_pkg::uwm_rx_s  rx;
  uwm_pkg::uwm_rx_s  next_rx;
  uwm_pkg::uwm_ctl_s ctl;
  uwm_pkg::uwm_ctl_s next_ctl;

  logic [DIV_WIDTH-1:0] baud_cnt;
  logic [DIV_WIDTH-1:0] next_baud_cnt;
  logic                 tick;
  logic                 next_tick;

  logic       loop;
  logic       div_sel;
  logic       tx_line;
  logic       rx_line;
  logic       tx_xfer;
  logic       wr_thr;
  logic       rx_done;
  logic       rx_pe;
  logic       rx_fe;
  logic       rx_bi;
  logic [3:0] modem_now;
  logic [2:0] src_code;
  logic       any_pend;
  logic [2:0] data_last;
  logic       par_en;

  // Parity over the active data bits, or the forced constant
  function automatic logic calc_parity(input logic [7:0] d,
                                       input logic [7:0] fmt);
    logic [7:0] m;
    m = d & (8'hff >> (3'h3 - fmt[1:0]));
    if (fmt[`UWM_FMT_STICK])
      calc_parity = ~fmt[`UWM_FMT_EVEN];
    else
      calc_parity = (^m) ^ ~fmt[`UWM_FMT_EVEN];
  endfunction : calc_parity

  // Index 0 and 1 reach the divisor while the divisor bit is set
  function automatic logic is_div(input logic [2:0] idx,
                                  input logic       dsel);
    is_div = dsel && (idx == `UWM_REG_DATA || idx == `UWM_REG_MASK);
  endfunction : is_div

  assign loop      = ctl.modem_output_control[`UWM_MCR_LOOP];
  assign div_sel   = ctl.line_format[`UWM_FMT_DIV];  // divisor_access_bit
  assign par_en    = ctl.line_format[`UWM_FMT_PEN];
  assign data_last = 3'(`UWM_LEN_BASE + {1'b0, ctl.line_format[1:0]});
  assign wr_thr    = wr_i && reg_select_i == `UWM_REG_DATA
                     && !is_div(reg_select_i, div_sel);

  // Internal transmit level; break drives it low even in loop-back
  assign tx_line = ctl.line_format[`UWM_FMT_BREAK] ? 1'b0
                                                    : tx.line;
  // Loop-back keeps the pin at mark and feeds the receiver inside
  assign serial_out_o = loop ? 1'b1 : tx_line;
  assign rx_line      = loop ? tx_line : serial_in_i;

  // Modem inputs, or the control bits when looped; bit order cts,dsr,ri,cd
  assign modem_now = loop ? {ctl.modem_output_control[3],
                             ctl.modem_output_control[2],
                             ctl.modem_output_control[0],
                             ctl.modem_output_control[1]}
                          : {~carrier_found_n_i, ~ring_indicate_n_i,
                             ~data_set_ready_n_i,
                             ~clear_to_send_n_i};

  // Modem output pins follow the stored control bits, inverted; the rest follow tick, irq and read data
  assign terminal_ready_n_o = ~ctl.modem_output_control[0];
  assign send_request_n_o   = ~ctl.modem_output_control[1];
  assign user_out_a_n_o     = ~ctl.modem_output_control[2];
  assign user_out_b_n_o     = ~ctl.modem_output_control[3];
  assign rate_clock_out_n_o = ~tick;
  assign interrupt_o        = ctl.irq;
  assign data_o             = ctl.rd_data;
  assign data_oe_o          = ctl.rd_oe;

  // Baud divider: one tick each divisor clocks; zero divisor stops it
  always_comb
  begin
    next_baud_cnt = baud_cnt;
    next_tick     = 1'b0;
    if (ctl.divisor != `UWM_DIV_RESET)
    begin
      if (baud_cnt <= DIV_WIDTH'(1))
      begin
        next_baud_cnt = ctl.divisor;
        next_tick     = 1'b1;
      end
      else
        next_baud_cnt = baud_cnt - DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      baud_cnt <= '0;
      tick     <= 1'b0;
    end
    else
    begin
      baud_cnt <= next_baud_cnt;
      tick     <= next_tick;
    end
  end

  // Transmitter; modem pins never enter this path
  always_comb
  begin
    next_tx = tx;
    tx_xfer = 1'b0;
    unique case (tx.phase)
      uwm_pkg::UWM_IDLE:
      begin
        next_tx.line = 1'b1;
        if (tx.hold_full)
        begin
          next_tx.tx_shifter = tx.hold;
          next_tx.hold_full  = 1'b0;
          next_tx.phase      = uwm_pkg::UWM_START;
          next_tx.ticks      = '0;
          next_tx.bits       = '0;
          next_tx.line       = 1'b0;
          tx_xfer            = 1'b1;
        end
      end
      uwm_pkg::UWM_START:
        if (tick)
        begin
          next_tx.ticks = 5'(tx.ticks + 5'h01);
          if (tx.ticks == `UWM_TICK_LAST)
          begin
            next_tx.ticks = '0;
            next_tx.phase = uwm_pkg::UWM_DATA;
            next_tx.line  = tx.tx_shifter[0];
          end
        end
      uwm_pkg::UWM_DATA:
        if (tick)
        begin
          next_tx.ticks = 5'(tx.ticks + 5'h01);
          if (tx.ticks == `UWM_TICK_LAST)
          begin
            next_tx.ticks = '0;
            if (tx.bits == data_last)
            begin
              next_tx.phase = par_en ? uwm_pkg::UWM_PARITY
                                     : uwm_pkg::UWM_STOP;
              next_tx.line  = par_en ?
                calc_parity(tx.tx_shifter,
                            ctl.line_format) : 1'b1;
            end
            else
            begin
              next_tx.bits = 3'(tx.bits + 3'h1);
              next_tx.line = tx.tx_shifter[3'(tx.bits + 3'h1)];
            end
          end
        end
      uwm_pkg::UWM_PARITY:
        if (tick)
        begin
          next_tx.ticks = 5'(tx.ticks + 5'h01);
          if (tx.ticks == `UWM_TICK_LAST)
          begin
            next_tx.ticks = '0;
            next_tx.phase = uwm_pkg::UWM_STOP;
            next_tx.line  = 1'b1;
          end
        end
      uwm_pkg::UWM_STOP:
        if (tick)
        begin
          next_tx.ticks = 5'(tx.ticks + 5'h01);
          // Long stop is 1.5 bits for 5-bit words, else 2 bits
          if (tx.ticks == (!ctl.line_format[`UWM_FMT_STOP]
                ? `UWM_TICK_LAST
                : (ctl.line_format[1:0] == `UWM_LEN_FIVE
                   ? `UWM_STOP15 : `UWM_STOP2)))
          begin
            next_tx.ticks = '0;
            next_tx.phase = uwm_pkg::UWM_IDLE;
          end
        end
      default:
        next_tx.phase = uwm_pkg::UWM_IDLE;
    endcase
    // A byte is taken only into a free holding register
    if (wr_thr && !tx.hold_full)
    begin
      next_tx.hold      = data_i;
      next_tx.hold_full = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      tx      <= '0;
      tx.line <= 1'b1;
    end
    else
      tx <= next_tx;
  end

  // Receiver: validated start bit, data, optional parity, stop
  always_comb
  begin
    next_rx           = rx;
    next_rx.prev_line = rx_line;
    rx_done           = 1'b0;
    rx_pe             = 1'b0;
    rx_fe             = 1'b0;
    rx_bi             = 1'b0;
    unique case (rx.phase)
      uwm_pkg::UWM_IDLE:
        if (rx.prev_line && !rx_line)
        begin
          next_rx.phase = uwm_pkg::UWM_START;
          next_rx.ticks = '0;
        end
      uwm_pkg::UWM_START:
        if (tick)
        begin
          next_rx.ticks = 5'(rx.ticks + 5'h01);
          if (rx.ticks == `UWM_MID_LAST)
          begin
            next_rx.ticks = '0;
            next_rx.bits  = '0;
            next_rx.shift = '0;
            // A high level here was a spike, not a start bit
            next_rx.phase = rx_line ? uwm_pkg::UWM_IDLE
                                    : uwm_pkg::UWM_DATA;
          end
        end
      uwm_pkg::UWM_DATA:
        if (tick)
        begin
          next_rx.ticks = 5'(rx.ticks + 5'h01);
          if (rx.ticks == `UWM_TICK_LAST)
          begin
            next_rx.ticks          = '0;
            next_rx.shift[rx.bits] = rx_line;
            next_rx.bits           = 3'(rx.bits + 3'h1);
            if (rx.bits == data_last)
              next_rx.phase = par_en ? uwm_pkg::UWM_PARITY
                                     : uwm_pkg::UWM_STOP;
          end
        end
      uwm_pkg::UWM_PARITY:
        if (tick)
        begin
          next_rx.ticks = 5'(rx.ticks + 5'h01);
          if (rx.ticks == `UWM_TICK_LAST)
          begin
            next_rx.ticks   = '0;
            next_rx.par_bit = rx_line;
            next_rx.phase   = uwm_pkg::UWM_STOP;
          end
        end
      uwm_pkg::UWM_STOP:
        if (tick)
        begin
          next_rx.ticks = 5'(rx.ticks + 5'h01);
          if (rx.ticks == `UWM_TICK_LAST)
          begin
            next_rx.ticks = '0;
            next_rx.phase = uwm_pkg::UWM_IDLE;
            rx_done       = 1'b1;
            rx_pe = par_en && rx.par_bit !=
                    calc_parity(rx.shift, ctl.line_format);
            rx_fe = !rx_line;
            rx_bi = !rx_line && rx.shift == 8'h00
                    && !(par_en && rx.par_bit);
          end
        end
      default:
        next_rx.phase = uwm_pkg::UWM_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      rx           <= '0;
      rx.prev_line <= 1'b1;
    end
    else
      rx <= next_rx;
  end

  // Highest pending enabled source wins the code
  always_comb
  begin
    any_pend = 1'b1;
    if (ctl.interrupt_mask[`UWM_MASK_LINE] && |ctl.errs)
      src_code = `UWM_SRC_LINE;
    else if (ctl.interrupt_mask[`UWM_MASK_RX] && ctl.rx_data_waiting)
      src_code = `UWM_SRC_RX;
    else if (ctl.interrupt_mask[`UWM_MASK_THRE] && ctl.thre_int)
      src_code = `UWM_SRC_THRE;
    else if (ctl.interrupt_mask[`UWM_MASK_MODEM] && |ctl.delta)
      src_code = `UWM_SRC_MODEM;
    else
    begin
      src_code = `UWM_SRC_NONE;
      any_pend = 1'b0;
    end
  end

  // Host registers, read side effects and status flags
  always_comb
  begin
    logic [7:0] rv;
    logic       rd_rbr;
    rv        = 8'h00;
    rd_rbr    = rd_i && reg_select_i == `UWM_REG_DATA
                && !is_div(reg_select_i, div_sel);
    next_ctl  = ctl;
    next_ctl.rd_oe      = rd_i;
    next_ctl.irq        = any_pend;
    next_ctl.modem_prev = modem_now;
    unique case (reg_select_i)
      `UWM_REG_DATA:  rv = div_sel ? ctl.divisor[7:0]
                                   : ctl.receive_buffer;
      `UWM_REG_MASK:  rv = div_sel ? ctl.divisor[15:8]
                                   : {4'h0, ctl.interrupt_mask};
      `UWM_REG_SRC:   rv = {5'h00, src_code};
      `UWM_REG_FMT:   rv = ctl.line_format;
      `UWM_REG_MCTL:  rv = {3'h0, ctl.modem_output_control};
      `UWM_REG_LSTAT: rv = {1'b0,
                            !tx.hold_full && tx.phase == uwm_pkg::UWM_IDLE,
                            !tx.hold_full, ctl.errs,
                            ctl.rx_data_waiting};
      `UWM_REG_MSTAT: rv = {ctl.modem_prev, ctl.delta};
      `UWM_REG_SCR:   rv = ctl.scratch_byte;
    endcase
    if (rd_i)
      next_ctl.rd_data = rv;
    // Reads that service a source clear it
    if (rd_rbr)
      next_ctl.rx_data_waiting = 1'b0;
    if (rd_i && reg_select_i == `UWM_REG_LSTAT)
      next_ctl.errs = 4'h0;
    if (rd_i && reg_select_i == `UWM_REG_MSTAT)
      next_ctl.delta = 4'h0;
    if (rd_i && reg_select_i == `UWM_REG_SRC && src_code == `UWM_SRC_THRE)
      next_ctl.thre_int = 1'b0;
    if (wr_i)
    begin
      unique case (reg_select_i)
        `UWM_REG_DATA:
          if (div_sel)
            next_ctl.divisor[7:0] = data_i;
          else
            next_ctl.thre_int = 1'b0;
        `UWM_REG_MASK:
          if (div_sel)
            next_ctl.divisor[15:8] = data_i;
          else
          begin
            next_ctl.interrupt_mask = data_i[3:0];
            // Enabling the empty source while empty raises it at once
            if (data_i[`UWM_MASK_THRE] && !tx.hold_full
                && !ctl.interrupt_mask[`UWM_MASK_THRE])
              next_ctl.thre_int = 1'b1;
          end
        `UWM_REG_FMT:   next_ctl.line_format = data_i;
        `UWM_REG_MCTL:  next_ctl.modem_output_control = data_i[4:0];
        `UWM_REG_SCR:   next_ctl.scratch_byte = data_i;
        default:        next_ctl.scratch_byte = ctl.scratch_byte;
      endcase
    end
    // Hardware sets come last so they win over a same-cycle clear
    if (tx_xfer)
      next_ctl.thre_int = 1'b1;
    if (rx_done)
    begin
      next_ctl.receive_buffer  = rx.shift;
      next_ctl.rx_data_waiting = 1'b1;
      // Overrun sets on top of any same-cycle status read clear
      next_ctl.errs[0] = next_ctl.errs[0]
                         | (ctl.rx_data_waiting & !rd_rbr);
      next_ctl.errs[1] = next_ctl.errs[1] | rx_pe;
      next_ctl.errs[2] = next_ctl.errs[2] | rx_fe;
      next_ctl.errs[3] = next_ctl.errs[3] | rx_bi;
    end
    next_ctl.delta[0] = next_ctl.delta[0] | (modem_now[0] ^ ctl.modem_prev[0]);
    next_ctl.delta[1] = next_ctl.delta[1] | (modem_now[1] ^ ctl.modem_prev[1]);
    next_ctl.delta[2] = next_ctl.delta[2]
                        | (ctl.modem_prev[2] & !modem_now[2]);
    next_ctl.delta[3] = next_ctl.delta[3] | (modem_now[3] ^ ctl.modem_prev[3]);
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      ctl            <= '0;
      ctl.divisor    <= `UWM_DIV_RESET;
      ctl.modem_prev <= modem_now;  // Sync reset: no false delta after
    end
    else
      ctl <= next_ctl;
  end

endmodule : uwm_top

// [verification/uwm_line_peer.sv]
// Null-modem peer model for the serial side of the port
`timescale 1ns/1ps
module uwm_line_peer (
  input  wire logic tx_line_i,
  input  wire logic rts_n_i,
  input  wire logic dtr_n_i,
  input  wire logic op_a_n_i,
  input  wire logic op_b_n_i,
  output logic      rx_line_o,
  output logic      cts_n_o,
  output logic      dsr_n_o,
  output logic      ri_n_o,
  output logic      cd_n_o
);
  // Plain wired plug: echo keeps sender timing, so format errors show
  assign rx_line_o = tx_line_i;
  // Crossed handshake so each control bit can be seen coming back
  assign cts_n_o   = rts_n_i;
  assign dsr_n_o   = dtr_n_i;
  assign ri_n_o    = op_a_n_i;
  assign cd_n_o    = op_b_n_i;
endmodule : uwm_line_peer

// [verification/uwm_top_assertions.sv]
// Port-level checker for the serial port, bound to its top module
`timescale 1ns/1ps
module uwm_checker #(
  parameter int DIV_WIDTH = 16
) (
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic [2:0] reg_select_i,
  input wire logic       rd_i,
  input wire logic       wr_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] data_o,
  input wire logic       data_oe_o,
  input wire logic       serial_out_o,
  input wire logic       terminal_ready_n_o,
  input wire logic       send_request_n_o,
  input wire logic       user_out_a_n_o,
  input wire logic       user_out_b_n_o,
  input wire logic       rate_clock_out_n_o,
  input wire logic       interrupt_o
);
  logic       fmt_div;
  logic       fmt_brk;
  logic       loop_on;
  logic [3:0] mctl;
  logic [3:0] mask;
  logic [7:0] scr;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // Shadow of the host writes, so outputs can be tied to their cause
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      {fmt_div, fmt_brk, loop_on, mctl, mask, scr} <= 19'h0;
    else if (wr_i)
    begin
      case (reg_select_i)
        3'h1: if (!fmt_div) mask <= data_i[3:0];
        3'h3: {fmt_div, fmt_brk} <= data_i[7:6];
        3'h4: {loop_on, mctl} <= data_i[4:0];
        3'h7: scr <= data_i;
        default: ;
      endcase
    end
  end

  a_reset_idle: assert property (
    $fell(sys_rst_i) |-> serial_out_o && !interrupt_o && !data_oe_o
      && rate_clock_out_n_o) else $error("Outputs not idle after reset");
  a_oe_follows: assert property (
    1'b1 |-> data_oe_o == $past(rd_i)) else $error("Bus enable off read");
  a_data_holds: assert property (
    !rd_i |=> $stable(data_o)) else $error("Read data moved without read");
  a_pins_follow: assert property (
    $stable(mctl) |-> {user_out_b_n_o, user_out_a_n_o, send_request_n_o,
      terminal_ready_n_o} == ~mctl) else $error("Modem pins wrong");
  a_irq_masked: assert property (
    (mask == 4'h0) [*2] |-> !interrupt_o) else $error("Masked interrupt");
  a_scratch_read: assert property (
    rd_i && reg_select_i == 3'h7 |=> data_o == $past(scr))
    else $error("Scratch byte read wrong");
  a_mask_read: assert property (
    rd_i && reg_select_i == 3'h1 && !fmt_div |=> data_o == {4'h0, $past(mask)})
    else $error("Mask read wrong");
  a_src_codes: assert property (
    rd_i && reg_select_i == 3'h2 |=> data_o[7:3] == 5'h00
      && !(data_o[0] && data_o[2:1] != 2'h0)) else $error("Bad source code");
  a_break_low: assert property (
    (fmt_brk && !loop_on) [*3] |-> !serial_out_o) else $error("No break");
  a_loop_mark: assert property (
    loop_on [*3] |-> serial_out_o) else $error("Output not mark in loop");
endmodule : uwm_checker

bind uwm_top uwm_checker #(.DIV_WIDTH(DIV_WIDTH)) u_uwm_checker (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_select_i(reg_select_i),
  .rd_i(rd_i), .wr_i(wr_i), .data_i(data_i), .data_o(data_o),
  .data_oe_o(data_oe_o), .serial_out_o(serial_out_o),
  .terminal_ready_n_o(terminal_ready_n_o),
  .send_request_n_o(send_request_n_o), .user_out_a_n_o(user_out_a_n_o),
  .user_out_b_n_o(user_out_b_n_o), .rate_clock_out_n_o(rate_clock_out_n_o),
  .interrupt_o(interrupt_o));

// [verification/uwm_top_bench.sv]
// Self-checking bench: host register traffic against a null-modem peer
`timescale 1ns/1ps
module uwm_top_bench;
  logic       clock_i      = 1'b0;
  logic       sys_rst_i    = 1'b1;
  logic [2:0] reg_select_i = 3'h0;
  logic       rd_i         = 1'b0;
  logic       wr_i         = 1'b0;
  logic [7:0] data_i       = 8'h00;
  logic [7:0] data_o;
  logic       data_oe_o;
  logic       serial_in_i;
  logic       serial_out_o;
  logic       cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n, op_a_n, op_b_n;
  logic       rate_n;
  logic       interrupt_o;
  int         num_errors = 0;
  int         checks     = 0;
  logic [7:0] fmts [8] = '{8'h00, 8'h04, 8'h0d, 8'h1e, 8'h2b, 8'h3f,
                           8'h07, 8'h1b};

  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  uwm_top u_uwm_top (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_select_i(reg_select_i),
    .rd_i(rd_i), .wr_i(wr_i), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o), .clear_to_send_n_i(cts_n),
    .data_set_ready_n_i(dsr_n), .ring_indicate_n_i(ri_n),
    .carrier_found_n_i(cd_n), .terminal_ready_n_o(dtr_n),
    .send_request_n_o(rts_n), .user_out_a_n_o(op_a_n),
    .user_out_b_n_o(op_b_n), .rate_clock_out_n_o(rate_n),
    .interrupt_o(interrupt_o));

  uwm_line_peer u_uwm_line_peer (
    .tx_line_i(serial_out_o), .rts_n_i(rts_n), .dtr_n_i(dtr_n),
    .op_a_n_i(op_a_n), .op_b_n_i(op_b_n), .rx_line_o(serial_in_i),
    .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n), .cd_n_o(cd_n));

  task automatic test_done();
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One-cycle strobes; a low cycle always separates two accesses
  task automatic wr(input logic [2:0] idx, input logic [7:0] val);
    @(posedge clock_i);
    reg_select_i <= idx;
    data_i       <= val;
    wr_i         <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] idx, output logic [7:0] val);
    @(posedge clock_i);
    reg_select_i <= idx;
    rd_i         <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 val = data_o;
  endtask : rd

  task automatic rdc(input logic [2:0] idx, input logic [7:0] exp,
                     input string what);
    logic [7:0] got;
    rd(idx, got);
    check(what, exp, got);
  endtask : rdc

  task automatic wait_irq();
    int n;
    n = 0;
    while (interrupt_o !== 1'b1)
    begin
      @(posedge clock_i);
      n++;
      if (n > 3000)
      begin
        check("interrupt wait", 8'h01, 8'h00);
        test_done();
      end
    end
  endtask : wait_irq

  // Polls line status; bounded so a stuck flag ends the run
  task automatic poll_ls(input int b, output logic [7:0] s);
    int n;
    n = 0;
    s = 8'h00;
    while (s[b] !== 1'b1)
    begin
      rd(3'h5, s);
      n++;
      if (n > 500)
      begin
        check("line status wait", 8'h01, 8'h00);
        test_done();
      end
    end
  endtask : poll_ls

  // Main sequence
  initial
  begin
    int         n;
    logic [7:0] v;
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rdc(3'h2, 8'h01, "source");
    rdc(3'h3, 8'h00, "format");
    rdc(3'h5, 8'h60, "line status");
    rdc(3'h6, 8'h00, "modem status");
    check("pins", 8'h0f, {4'h0, op_b_n, op_a_n, rts_n, dtr_n});
    wr(3'h7, 8'ha5);
    rdc(3'h7, 8'ha5, "scratch");
    wr(3'h1, 8'hf5);
    rdc(3'h1, 8'h05, "mask");
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h02);
    wr(3'h1, 8'h00);
    rdc(3'h0, 8'h02, "divisor low");
    rdc(3'h1, 8'h00, "divisor high");
    wr(3'h3, 8'h03);
    rdc(3'h1, 8'h05, "mask after divisor");
    n = 0;
    repeat (20)
    begin
      @(posedge clock_i);
      #1 if (rate_n === 1'b0) n++;
    end
    check("rate lows", 8'h0a, n[7:0]);
    // Modem status through the crossed plug
    wr(3'h1, 8'h08);
    wr(3'h4, 8'h0f);
    #1 check("pins", 8'h00, {4'h0, op_b_n, op_a_n, rts_n, dtr_n});
    wait_irq();
    rdc(3'h2, 8'h00, "source modem");
    rdc(3'h6, 8'hfb, "modem status");
    rdc(3'h2, 8'h01, "source cleared");
    wr(3'h4, 8'h00);
    wait_irq();
    rdc(3'h6, 8'h0f, "modem status");
    // Echoed characters in every length, stop and parity mode
    wr(3'h1, 8'h01);
    foreach (fmts[i])
    begin
      wr(3'h3, fmts[i]);
      wr(3'h0, 8'ha7);
      // Parity bit on the pin, mid-bit, for the 8-bit parity formats
      if (fmts[i][3] && fmts[i][1:0] == 2'h3)
      begin
        repeat (305) @(posedge clock_i);
        v = {7'h0, (fmts[i][5] ? ~fmts[i][4] : ~fmts[i][4] ^ (^8'ha7))};
        #1 check("parity bit", v, {7'h0, serial_out_o});
      end
      wait_irq();
      poll_ls(0, v);
      check("rx errors", 8'h01, {3'h0, v[4:0]});
      rdc(3'h0, 8'ha7 & (8'hff >> (2'h3 - fmts[i][1:0])), "rx");
      poll_ls(6, v);
    end
    // Receive and holding-empty both pending: order of service
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h03);
    wr(3'h0, 8'h81);
    poll_ls(0, v);
    rdc(3'h2, 8'h04, "source rx");
    rdc(3'h0, 8'h81, "rx");
    rdc(3'h2, 8'h02, "source tx empty");
    rdc(3'h2, 8'h01, "source none");
    repeat (2) @(posedge clock_i);
    #1 check("interrupt", 8'h00, {7'h0, interrupt_o});
    // Short break is too brief to pass the mid-bit check
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h43);
    repeat (3) @(posedge clock_i);
    wr(3'h3, 8'h03);
    repeat (60) @(posedge clock_i);
    rdc(3'h5, 8'h60, "after glitch");
    // Loop-back keeps the line at mark and still receives
    wr(3'h1, 8'h01);
    wr(3'h4, 8'h1f);
    wr(3'h0, 8'h3c);
    wait_irq();
    // Second byte lands while the first is unread: overrun
    wr(3'h1, 8'h05);
    wr(3'h0, 8'h3c);
    repeat (400) @(posedge clock_i);
    rdc(3'h2, 8'h06, "source line");
    rdc(3'h5, 8'h63, "overrun status");
    rdc(3'h0, 8'h3c, "loop rx");
    rd(3'h6, v);
    check("loop modem", 8'hf0, {v[7:4], 4'h0});
    wr(3'h4, 8'h00);
    test_done();
  end
endmodule : uwm_top_bench
